// file: rtl/tcm_defs.svh
`ifndef TCM_DEFS_SVH
`define TCM_DEFS_SVH

// ==================================================
// channel word layout
`define TCM_DATA_W       12
`define TCM_CHAR_W       8
`define TCM_UNIT_LSB     0
`define TCM_UNIT_W       3
`define TCM_SECT_BIT     3
`define TCM_CAB_LSB      4
`define TCM_CAB_W        8
`define TCM_CAB_ID_RST   8'h00
`define TCM_NUM_UNITS    16
`define TCM_IDX_W        4

// ==================================================
// character lengths
`define TCM_SHORT_LEN    4'h5
`define TCM_LONG_LEN     4'h8

// ==================================================
// pin synchroniser layout and reset (lines idle marking)
`define TCM_SYNC_W       32
`define TCM_SYNC_RST     32'hffff_0000

// ==================================================
// timing
`define TCM_CLK_MHZ        100
`define TCM_IRQ_PERIOD_MS  90
`define TCM_IRQ_CYCLES     (`TCM_IRQ_PERIOD_MS * 1000 * `TCM_CLK_MHZ)
`define TCM_BIT_TIME_US    22000
`define TCM_BIT_CYCLES     (`TCM_BIT_TIME_US * `TCM_CLK_MHZ)
`define TCM_MOTOR_DELAY_S  4
`define TCM_MOTOR_CYCLES   (`TCM_MOTOR_DELAY_S * 1000000 * `TCM_CLK_MHZ)
`endif

// file: rtl/tcm_pkg.sv
`include "tcm_defs.svh"
package tcm_pkg;
   // ==================================================
   // decoded connect code, cabinet above section above unit
   typedef struct packed {
      logic [`TCM_CAB_W-1:0]  cabinet;
      logic                   section;
      logic [`TCM_UNIT_W-1:0] unit;
   } tcm_code_t;

   // synchronised channel pins
   typedef struct packed {
      logic                   connect;
      logic                   read;
      logic                   write;
      logic                   strobe;
      logic [`TCM_DATA_W-1:0] data;
   } tcm_chan_t;

   // code on the three status lines
   typedef enum logic [2:0] {
      STS_NONE,
      STS_READY,
      STS_LOST,
      STS_BREAK,
      STS_IDLE,
      STS_REQUEST
   } tcm_status_t;

   typedef enum logic [2:0] {
      ST_IDLE,
      ST_SCAN,
      ST_FETCH,
      ST_SHOW,
      ST_ANS,
      ST_HOLD
   } tcm_state_t;
endpackage

// file: rtl/tcm_char_mem.sv
`timescale 1ns/1ps
`include "tcm_defs.svh"
module tcm_char_mem (
   input  wire logic                                       clk_i,
   input  wire logic                                       srst_i,
   input  wire logic                                       ce_i,
   input  wire logic [`TCM_NUM_UNITS-1:0]                  wr_en_i,
   input  wire logic [`TCM_NUM_UNITS-1:0][`TCM_CHAR_W-1:0] wr_data_i,
   input  wire logic [`TCM_IDX_W-1:0]                      rd_addr_i,
   output logic      [`TCM_CHAR_W-1:0]                     rd_data_o
);
   logic [`TCM_NUM_UNITS-1:0][`TCM_CHAR_W-1:0] mem_reg;
   logic [`TCM_NUM_UNITS-1:0][`TCM_CHAR_W-1:0] mem_next;
   logic [`TCM_CHAR_W-1:0]                     rd_reg;

   // ==================================================
   // one write port per input unit, so finishing lines never collide
   always_comb begin
      mem_next = mem_reg;
      for (int i = 0; i < `TCM_NUM_UNITS; i++) begin
         if (wr_en_i[i]) begin
            mem_next[i] = wr_data_i[i];
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         mem_reg <= '0;
         rd_reg  <= '0;
      end else if (ce_i) begin
         mem_reg <= mem_next;
         rd_reg  <= mem_reg[rd_addr_i];  // registered read, one cycle late
      end
   end

   assign rd_data_o = rd_reg;
endmodule

// file: rtl/tcm_mux.sv
`timescale 1ns/1ps
`include "tcm_defs.svh"
module tcm_mux
   import tcm_pkg::*;
#(
   parameter int unsigned          IRQ_CYCLES   = `TCM_IRQ_CYCLES,
   parameter int unsigned          BIT_CYCLES   = `TCM_BIT_CYCLES,
   parameter int unsigned          MOTOR_CYCLES = `TCM_MOTOR_CYCLES,
   parameter logic [`TCM_CAB_W-1:0] CAB_ID      = `TCM_CAB_ID_RST   // arbitrary cabinet code
)(
   input  wire logic                      clk_i,
   input  wire logic                      srst_i,
   input  wire logic                      ce_i,
   input  wire logic                      scan_en_i,
   input  wire logic                      motor_delay_en_i,
   input  wire logic [`TCM_NUM_UNITS-1:0] long_char_i,
   input  wire logic [`TCM_DATA_W-1:0]    data_i,
   output logic      [`TCM_DATA_W-1:0]    data_o,
   output logic                           data_oe_o,
   input  wire logic                      connect_i,
   input  wire logic                      read_i,
   input  wire logic                      write_i,
   input  wire logic                      dstrobe_i,
   output logic                           reply_o,
   output logic      [2:0]                status_o,
   output logic                           interrupt_o,
   output logic      [1:0]                sect_lamp_o,
   output logic      [`TCM_UNIT_W-1:0]    unit_lamp_o,
   input  wire logic [`TCM_NUM_UNITS-1:0] rx_line_i,
   output logic      [`TCM_NUM_UNITS-1:0] tx_line_o,
   output logic      [`TCM_NUM_UNITS-1:0] motor_run_o
);
   // ==================================================
   // pin synchronisers, all channel and line pins are asynchronous
   logic [`TCM_SYNC_W-1:0] pin_meta_reg;
   logic [`TCM_SYNC_W-1:0] pin_sync_reg;
   tcm_chan_t              chan;
   logic [`TCM_NUM_UNITS-1:0] rx_s;

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         pin_meta_reg <= `TCM_SYNC_RST;
         pin_sync_reg <= `TCM_SYNC_RST;
      end else if (ce_i) begin
         pin_meta_reg <= {rx_line_i, connect_i, read_i, write_i, dstrobe_i, data_i};
         pin_sync_reg <= pin_meta_reg;
      end
   end

   assign rx_s = pin_sync_reg[`TCM_SYNC_W-1 -: `TCM_NUM_UNITS];
   assign chan = tcm_chan_t'(pin_sync_reg[`TCM_DATA_W+3:0]);

   // ==================================================
   // status priority for one unit pair
   function automatic tcm_status_t unit_status(input logic rdy, input logic lost,
                                               input logic brk, input logic idl,
                                               input logic req);
      unit_status = STS_NONE;
      if (rdy) begin
         unit_status = STS_READY;
      end else if (lost) begin
         unit_status = STS_LOST;
      end else if (brk) begin
         unit_status = STS_BREAK;
      end else if (req) begin
         unit_status = STS_REQUEST;
      end else if (idl) begin
         unit_status = STS_IDLE;
      end
   endfunction

   // ==================================================
   // shared state between channel control and the line units
   logic [`TCM_NUM_UNITS-1:0]                  rdy_w;
   logic [`TCM_NUM_UNITS-1:0]                  lost_w;
   logic [`TCM_NUM_UNITS-1:0]                  brk_w;
   logic [`TCM_NUM_UNITS-1:0]                  idle_w;
   logic [`TCM_NUM_UNITS-1:0]                  req_w;
   logic [`TCM_NUM_UNITS-1:0]                  mem_wr;
   logic [`TCM_NUM_UNITS-1:0][`TCM_CHAR_W-1:0] mem_wdata;
   logic [`TCM_CHAR_W-1:0]                     mem_rdata;
   logic                                       rd_take;
   logic                                       wr_take;
   logic [`TCM_IDX_W-1:0]                      sel_reg;

   // ==================================================
   // input units: start bit, mid-bit sampling, stop check
   for (genvar u = 0; u < `TCM_NUM_UNITS; u++) begin : g_rx
      logic                   busy_reg, busy_next;
      logic [3:0]             cnt_reg, cnt_next;
      logic [31:0]            tmr_reg, tmr_next;
      logic [`TCM_CHAR_W-1:0] sh_reg, sh_next;
      logic                   rdy_reg, rdy_next;
      logic                   lost_reg, lost_next;
      logic                   brk_reg, brk_next;
      logic                   clr;
      logic [3:0]             len;

      assign clr = rd_take && (sel_reg == u);
      assign len = long_char_i[u] ? `TCM_LONG_LEN : `TCM_SHORT_LEN;

      always_comb begin
         busy_next = busy_reg;
         cnt_next  = cnt_reg;
         tmr_next  = tmr_reg;
         sh_next   = sh_reg;
         rdy_next  = rdy_reg;
         lost_next = lost_reg;
         brk_next  = brk_reg;
         mem_wr[u] = 1'b0;
         if (clr) begin
            rdy_next  = 1'b0;
            lost_next = 1'b0;
            brk_next  = 1'b0;
         end
         if (!busy_reg) begin
            if (!rx_s[u]) begin
               busy_next = 1'b1;
               cnt_next  = 4'h0;
               sh_next   = '0;  // stale bits would hide a short break
               tmr_next  = 32'(BIT_CYCLES / 2);  // land mid start bit
            end
         end else if (tmr_reg != 32'h0) begin
            tmr_next = tmr_reg - 32'h1;
         end else begin
            tmr_next = 32'(BIT_CYCLES - 1);
            if (cnt_reg == 4'h0) begin
               if (rx_s[u]) begin
                  busy_next = 1'b0;  // glitch, not a start bit
               end else begin
                  cnt_next = 4'h1;
               end
            end else if (cnt_reg <= len) begin
               sh_next  = {rx_s[u], sh_reg[`TCM_CHAR_W-1:1]};
               cnt_next = cnt_reg + 4'h1;
            end else begin
               busy_next = 1'b0;
               if (rx_s[u]) begin
                  mem_wr[u] = 1'b1;
                  rdy_next  = 1'b1;  // new character beats a clear
                  if (rdy_reg && !clr) begin
                     lost_next = 1'b1;  // unread character overwritten
                  end
               end else if (sh_reg == '0) begin
                  brk_next = 1'b1;
               end
            end
         end
      end

      always_ff @(posedge clk_i) begin
         if (srst_i) begin
            busy_reg <= 1'b0;
            cnt_reg  <= 4'h0;
            tmr_reg  <= 32'h0;
            sh_reg   <= '0;
            rdy_reg  <= 1'b0;
            lost_reg <= 1'b0;
            brk_reg  <= 1'b0;
         end else if (ce_i) begin
            busy_reg <= busy_next;
            cnt_reg  <= cnt_next;
            tmr_reg  <= tmr_next;
            sh_reg   <= sh_next;
            rdy_reg  <= rdy_next;
            lost_reg <= lost_next;
            brk_reg  <= brk_next;
         end
      end

      // short characters arrive in the top bits, bring them down
      assign mem_wdata[u] = long_char_i[u] ? sh_reg : {3'h0, sh_reg[7:3]};
      assign rdy_w[u]     = rdy_reg;
      assign lost_w[u]    = lost_reg;
      assign brk_w[u]     = brk_reg;
      assign idle_w[u]    = rx_s[u] && !busy_reg;
   end

   tcm_char_mem tcm_char_mem_inst (
      .clk_i     (clk_i),
      .srst_i    (srst_i),
      .ce_i      (ce_i),
      .wr_en_i   (mem_wr),
      .wr_data_i (mem_wdata),
      .rd_addr_i (sel_reg),
      .rd_data_o (mem_rdata)
   );

   // ==================================================
   // output units: hold register, motor start, start-data-stop frame
   logic [`TCM_CHAR_W-1:0] wr_char;
   logic [`TCM_NUM_UNITS-1:0] tx_line_w;
   logic [`TCM_NUM_UNITS-1:0] motor_w;

   for (genvar u = 0; u < `TCM_NUM_UNITS; u++) begin : g_tx
      logic                   full_reg, full_next;
      logic [`TCM_CHAR_W-1:0] hold_reg, hold_next;
      logic                   busy_reg, busy_next;
      logic [3:0]             cnt_reg, cnt_next;
      logic [31:0]            tmr_reg, tmr_next;
      logic [9:0]             sh_reg, sh_next;
      logic                   line_reg, line_next;
      logic                   mot_reg, mot_next;
      logic [31:0]            mtmr_reg, mtmr_next;
      logic [3:0]             len;

      assign len = long_char_i[u] ? `TCM_LONG_LEN : `TCM_SHORT_LEN;

      always_comb begin
         full_next = full_reg;
         hold_next = hold_reg;
         busy_next = busy_reg;
         cnt_next  = cnt_reg;
         tmr_next  = tmr_reg;
         sh_next   = sh_reg;
         line_next = line_reg;
         mot_next  = mot_reg && motor_delay_en_i;
         mtmr_next = mtmr_reg;
         if (wr_take && (sel_reg == u) && !full_reg) begin
            full_next = 1'b1;
            hold_next = wr_char;
         end
         if (!busy_reg) begin
            if (full_reg) begin
               if (motor_delay_en_i && !mot_reg) begin
                  // let the far printer motor reach speed first
                  if (mtmr_reg >= 32'(MOTOR_CYCLES - 1)) begin
                     mot_next  = 1'b1;
                     mtmr_next = 32'h0;
                  end else begin
                     mtmr_next = mtmr_reg + 32'h1;
                  end
               end else begin
                  busy_next = 1'b1;
                  full_next = 1'b0;
                  cnt_next  = 4'h0;
                  tmr_next  = 32'h0;
                  sh_next   = {1'b1, long_char_i[u] ? hold_reg : {3'h7, hold_reg[4:0]}, 1'b0};
               end
            end
         end else if (tmr_reg != 32'h0) begin
            tmr_next = tmr_reg - 32'h1;
         end else if (cnt_reg == len + 4'h2) begin
            busy_next = 1'b0;  // stop bit done, line rests marking
         end else begin
            line_next = sh_reg[0];
            sh_next   = {1'b1, sh_reg[9:1]};
            cnt_next  = cnt_reg + 4'h1;
            tmr_next  = 32'(BIT_CYCLES - 1);
         end
      end

      always_ff @(posedge clk_i) begin
         if (srst_i) begin
            full_reg <= 1'b0;
            hold_reg <= '0;
            busy_reg <= 1'b0;
            cnt_reg  <= 4'h0;
            tmr_reg  <= 32'h0;
            sh_reg   <= 10'h3ff;
            line_reg <= 1'b1;
            mot_reg  <= 1'b0;
            mtmr_reg <= 32'h0;
         end else if (ce_i) begin
            full_reg <= full_next;
            hold_reg <= hold_next;
            busy_reg <= busy_next;
            cnt_reg  <= cnt_next;
            tmr_reg  <= tmr_next;
            sh_reg   <= sh_next;
            line_reg <= line_next;
            mot_reg  <= mot_next;
            mtmr_reg <= mtmr_next;
         end
      end

      assign req_w[u]     = !full_reg;  // character request
      assign tx_line_w[u] = line_reg;
      assign motor_w[u]   = mot_reg;
   end

   assign tx_line_o   = tx_line_w;
   assign motor_run_o = motor_w;

   // ==================================================
   // channel control: connect decode, scan, read and write handshake
   tcm_state_t             state_reg, state_next;
   tcm_code_t              code;
   logic                   conn_reg, conn_next;
   logic [`TCM_IDX_W-1:0]  sel_next;
   logic [`TCM_IDX_W-1:0]  scan_cnt_reg, scan_cnt_next;
   logic [`TCM_DATA_W-1:0] data_reg, data_next;
   logic                   oe_reg, oe_next;
   logic                   reply_reg, reply_next;
   logic [2:0]             sts_reg, sts_next;
   logic                   irq_reg, irq_next;
   logic [31:0]            irq_cnt_reg, irq_cnt_next;
   logic [1:0]             sect_lamp_reg, sect_lamp_next;
   logic [`TCM_UNIT_W-1:0] unit_lamp_reg, unit_lamp_next;

   assign code    = tcm_code_t'(chan.data);
   assign wr_char = chan.data[`TCM_CHAR_W-1:0];

   always_comb begin
      state_next    = state_reg;
      conn_next     = conn_reg;
      sel_next      = sel_reg;
      scan_cnt_next = scan_cnt_reg;
      data_next     = data_reg;
      oe_next       = oe_reg;
      reply_next    = reply_reg;
      rd_take       = 1'b0;
      wr_take       = 1'b0;
      irq_next      = irq_reg;
      irq_cnt_next  = irq_cnt_reg + 32'h1;
      unique case (state_reg)
         ST_IDLE: begin
            if (chan.connect) begin
               // foreign cabinet code: stay silent, let that cabinet answer
               conn_next  = (code.cabinet == CAB_ID);
               state_next = ST_HOLD;
               if (code.cabinet == CAB_ID) begin
                  sel_next   = {code.section, code.unit};
                  reply_next = 1'b1;
                  irq_next   = 1'b0;
               end
            end else if (chan.strobe && conn_reg && chan.write) begin
               wr_take    = 1'b1;
               reply_next = 1'b1;
               state_next = ST_HOLD;
            end else if (chan.strobe && conn_reg && chan.read) begin
               scan_cnt_next = '0;
               state_next    = scan_en_i ? ST_SCAN : ST_FETCH;
            end
         end
         ST_SCAN: begin
            // starts at the selected unit itself, then steps up through all 16 units with wrap
            if (rdy_w[sel_reg]) begin
               state_next = ST_FETCH;
            end else if (scan_cnt_reg == 4'hf) begin
               state_next = ST_FETCH;
            end else begin
               sel_next      = sel_reg + 4'h1;
               scan_cnt_next = scan_cnt_reg + 4'h1;
            end
         end
         ST_FETCH: begin
            state_next = ST_SHOW;  // memory read takes one cycle
         end
         ST_SHOW: begin
            data_next  = rdy_w[sel_reg] ? {4'h0, mem_rdata} : '0;
            oe_next    = 1'b1;
            rd_take    = rdy_w[sel_reg];
            state_next = ST_ANS;
         end
         ST_ANS: begin
            reply_next = 1'b1;
            state_next = ST_HOLD;
         end
         ST_HOLD: begin
            if (!chan.connect && !chan.strobe) begin
               reply_next = 1'b0;
               oe_next    = 1'b0;
               state_next = ST_IDLE;
            end
         end
      endcase
      // periodic service request; a new tick wins over the clear
      if (irq_cnt_reg >= 32'(IRQ_CYCLES - 1)) begin
         irq_cnt_next = 32'h0;
         irq_next     = 1'b1;
      end
      sts_next = conn_reg ? unit_status(rdy_w[sel_reg], lost_w[sel_reg], brk_w[sel_reg],
                                        idle_w[sel_reg], req_w[sel_reg]) : STS_NONE;
      // lamps follow the connection, registered so the panel pins stay clean
      sect_lamp_next = conn_next ? {~sel_next[3], sel_next[3]} : 2'h0;
      unit_lamp_next = conn_next ? sel_next[2:0] : 3'h0;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         state_reg    <= ST_IDLE;
         conn_reg     <= 1'b0;
         sel_reg      <= '0;
         scan_cnt_reg <= '0;
         data_reg     <= '0;
         oe_reg       <= 1'b0;
         reply_reg    <= 1'b0;
         sts_reg      <= 3'h0;
         irq_reg      <= 1'b0;
         irq_cnt_reg  <= 32'h0;
         sect_lamp_reg <= 2'h0;
         unit_lamp_reg <= 3'h0;
      end else if (ce_i) begin
         state_reg    <= state_next;
         conn_reg     <= conn_next;
         sel_reg      <= sel_next;
         scan_cnt_reg <= scan_cnt_next;
         data_reg     <= data_next;
         oe_reg       <= oe_next;
         reply_reg    <= reply_next;
         sts_reg      <= sts_next;
         irq_reg      <= irq_next;
         irq_cnt_reg  <= irq_cnt_next;
         sect_lamp_reg <= sect_lamp_next;
         unit_lamp_reg <= unit_lamp_next;
      end
   end

   // ==================================================
   // channel outputs and section/unit lamps (section A = bit 1)
   assign data_o      = data_reg;
   assign data_oe_o   = oe_reg;
   assign reply_o     = reply_reg;
   assign status_o    = sts_reg;
   assign interrupt_o = irq_reg;
   assign sect_lamp_o = sect_lamp_reg;
   assign unit_lamp_o = unit_lamp_reg;
endmodule

// file: dv/tcm_mux_chk.sv
`timescale 1ns/1ps
// ====
// channel handshake checks
module tcm_mux_chk
   import tcm_pkg::*;
#(
   parameter int unsigned IRQ_CYCLES = 200,
   parameter logic [7:0]  CAB_ID     = 8'h00
)(
   input wire logic        clk_i,
   input wire logic        srst_i,
   input wire logic [11:0] data_i,
   input wire logic [11:0] data_o,
   input wire logic        data_oe_o,
   input wire logic        connect_i,
   input wire logic        read_i,
   input wire logic        dstrobe_i,
   input wire logic        reply_o,
   input wire logic        interrupt_o,
   input wire logic [1:0]  sect_lamp_o,
   input wire logic [2:0]  unit_lamp_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (srst_i);
   logic [31:0] quiet_reg;
   logic [31:0] quiet_next;
   // gap counter, so a stalled period timer is caught
   always_comb begin
      quiet_next = interrupt_o ? 32'h0 : quiet_reg + 32'h1;
   end
   always_ff @(posedge clk_i) begin
      quiet_reg <= srst_i ? 32'h0 : quiet_next;
   end
   a_irq_period: assert property (quiet_reg <= IRQ_CYCLES + 3)
      else $error("interrupt gap too long");
   a_irq_sticky: assert property (interrupt_o && !connect_i |=> interrupt_o)
      else $error("interrupt dropped early");
   a_irq_clear: assert property ($rose(reply_o) && connect_i |-> ##[0:2] !interrupt_o)
      else $error("interrupt not cleared");
   a_conn_reply: assert property ($rose(connect_i) && data_i[11:4] == CAB_ID |-> ##[3:5] reply_o)
      else $error("no connect reply");
   a_bad_cab: assert property ($rose(connect_i) && data_i[11:4] != CAB_ID |-> !reply_o [*8])
      else $error("foreign code answered");
   a_lamp_code: assert property (reply_o && connect_i |->
      sect_lamp_o == {!data_i[3], data_i[3]} && unit_lamp_o == data_i[2:0])
      else $error("lamps differ from code");
   a_reply_cause: assert property ($rose(reply_o) |-> $past(connect_i || dstrobe_i, 2))
      else $error("reply without request");
   a_reply_hold: assert property (reply_o && (connect_i || dstrobe_i) |=> reply_o)
      else $error("reply fell early");
   a_reply_drop: assert property ((!connect_i && !dstrobe_i) [*5] |-> !reply_o)
      else $error("reply stuck");
   a_data_first: assert property ($rose(reply_o) && read_i |-> $past(data_oe_o))
      else $error("reply before data");
   a_low_byte: assert property (data_oe_o |-> data_o[11:8] == 4'h0)
      else $error("upper data bits set");
   a_oe_read: assert property ($rose(data_oe_o) |-> read_i && dstrobe_i)
      else $error("lines driven outside read");
endmodule
bind tcm_mux tcm_mux_chk #(.IRQ_CYCLES(IRQ_CYCLES), .CAB_ID(CAB_ID)) tcm_mux_chk_inst (
   .clk_i, .srst_i, .data_i, .data_o, .data_oe_o, .connect_i, .read_i, .dstrobe_i,
   .reply_o, .interrupt_o, .sect_lamp_o, .unit_lamp_o);

// file: dv/tcm_chan_model.sv
`timescale 1ns/1ps
// ====
// computer side of the channel
module tcm_chan_model (
   input  wire logic        clk_i,
   input  wire logic        reply_i,
   input  wire logic [11:0] line_i,
   output logic      [11:0] data_o,
   output logic             connect_o,
   output logic             read_o,
   output logic             write_o,
   output logic             dstrobe_o
);
   // strobes idle low, lines carry junk
   initial begin
      data_o = 12'ha5a;
      {connect_o, read_o, write_o, dstrobe_o} = 4'h0;
   end
   // kind 0 connect, 1 write, 2 read; ok low when unanswered
   task automatic xfer(input logic [1:0] kind, input logic [11:0] word,
                       output logic [11:0] rdata, output logic ok);
      int n;
      ok = 1'b0;
      rdata = 12'h000;
      @(posedge clk_i);
      data_o <= word;
      connect_o <= kind == 2'd0;
      write_o <= kind == 2'd1;
      read_o <= kind == 2'd2;
      dstrobe_o <= kind != 2'd0;
      // hold all up to the edge that sees reply, take the answer there
      for (n = 0; n < 40 && !ok; n++) begin
         @(posedge clk_i);
         ok = reply_i;
         rdata = line_i;
      end
      data_o <= ~word; // released lines show no stale value
      {connect_o, read_o, write_o, dstrobe_o} <= 4'h0;
      for (n = 0; n < 40 && reply_i; n++) @(negedge clk_i);
      repeat (4) @(posedge clk_i);
   endtask
endmodule

// file: dv/tcm_mux_test.sv
`timescale 1ns/1ps
// ====
// bench for the channel multiplexer
module tcm_mux_test;
   import tcm_pkg::*;
   logic        clk_i, srst_i, scan_en_i, data_oe_o, connect_i, read_i, ok;
   logic        write_i, dstrobe_i, reply_o, interrupt_o, motor_delay_en_i;
   logic [15:0] rx_line_i, tx_line_o, long_char_i, motor_run_o;
   logic [11:0] data_i, data_o, host_data, rd;
   logic [2:0]  status_o, unit_lamp_o;
   logic [1:0]  sect_lamp_o;
   int          error_cnt = 0;
   int          n_compared = 0;
   int          cyc = 0;
   // device wins the shared lines while it drives them
   assign data_i = data_oe_o ? data_o : host_data;
   tcm_mux #(.IRQ_CYCLES(200), .BIT_CYCLES(8), .MOTOR_CYCLES(50)) tcm_mux_inst (
      .clk_i, .srst_i, .ce_i(1'b1), .scan_en_i, .motor_delay_en_i,
      .long_char_i, .data_i, .data_o, .data_oe_o, .connect_i, .read_i,
      .write_i, .dstrobe_i, .reply_o, .status_o, .interrupt_o, .sect_lamp_o,
      .unit_lamp_o, .rx_line_i, .tx_line_o, .motor_run_o);
   tcm_chan_model tcm_chan_model_inst (.clk_i, .reply_i(reply_o), .line_i(data_i),
      .data_o(host_data), .connect_o(connect_i), .read_o(read_i), .write_o(write_i),
      .dstrobe_o(dstrobe_i));
   // ====
   // helpers
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic xfer(input logic [1:0] k, input logic [11:0] w);
      tcm_chan_model_inst.xfer(k, w, rd, ok);
   endtask
   // start low, data lsb first, stop high, 8 cycles a bit
   task automatic send_char(input int u, input logic [7:0] c);
      logic [9:0] fr = {1'b1, c, 1'b0};
      for (int i = 0; i < 10; i++) begin
         rx_line_i[u] <= fr[i];
         repeat (8) @(posedge clk_i);
      end
   endtask
   task final_report;
      $display("Compared %0d, errors %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ====
   // scenarios
   task automatic t_irq;
      for (int n = 0; n < 260 && interrupt_o !== 1'b1; n++) @(negedge clk_i);
      check(16'(interrupt_o), 16'h1);
      xfer(2'd0, 12'h00d);
      check(16'(ok), 16'h1);
      check(16'({sect_lamp_o, unit_lamp_o}), 16'h0d);
      check(16'(interrupt_o), 16'h0);
   endtask
   // shifter starts while the handshake still runs
   task automatic t_write;
      logic [8:0] fr = 9'h1a6;
      fork
         xfer(2'd1, 12'h0a6);
         begin
            for (int n = 0; n < 60 && tx_line_o[13] !== 1'b0; n++) @(negedge clk_i);
            repeat (4) @(negedge clk_i);
            check(16'(tx_line_o[13]), 16'h0);
            for (int i = 0; i < 9; i++) begin
               repeat (8) @(negedge clk_i);
               check(16'(tx_line_o[13]), 16'(fr[i]));
               check(tx_line_o | 16'h2000, 16'hffff);
            end
         end
      join
      check(16'(ok), 16'h1);
      check(16'(status_o), 16'h5);
   endtask
   // held character waits for the motor, then the flag rises
   task automatic t_motor;
      @(posedge clk_i);
      motor_delay_en_i <= 1'b1;
      xfer(2'd1, 12'h055);
      check(16'({motor_run_o[13], tx_line_o[13]}), 16'h1);
      repeat (50) @(posedge clk_i);
      check(16'(motor_run_o[13]), 16'h1);
      motor_delay_en_i <= 1'b0;
   endtask
   task automatic t_refuse;
      xfer(2'd0, 12'h10d);
      check(16'(ok), 16'h0);
      check(16'({sect_lamp_o, unit_lamp_o}), 16'h0);
   endtask
   task automatic t_read;
      send_char(2, 8'he5); // five-bit unit, top bits rest marking
      repeat (20) @(posedge clk_i);
      xfer(2'd0, 12'h002);
      check(16'(status_o), 16'h1);
      xfer(2'd2, 12'h000);
      check(16'({ok, rd}), 16'h1005);
      xfer(2'd2, 12'h000);
      check(16'({ok, rd}), 16'h1000);
      check(16'(status_o), 16'h5);
   endtask
   task automatic t_scan;
      scan_en_i <= 1'b1;
      send_char(11, 8'h3e);
      repeat (20) @(posedge clk_i);
      xfer(2'd0, 12'h000);
      xfer(2'd2, 12'h000);
      check(16'({ok, rd}), 16'h103e);
      scan_en_i <= 1'b0;
   endtask
   // ====
   // clock, watchdog and main sequence
   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      cyc++;
      if (cyc == 20000) begin
         error_cnt++;
         final_report();
      end
   end
   initial begin
      srst_i = 1'b1;
      scan_en_i = 1'b0;
      rx_line_i = 16'hffff;
      motor_delay_en_i = 1'b0;
      long_char_i = 16'hfffb; // unit 2 takes five-bit characters
      repeat (12) @(posedge clk_i);
      srst_i <= 1'b0;
      check(tx_line_o, 16'hffff);
      t_irq();
      t_write();
      t_motor();
      t_refuse();
      t_read();
      t_scan();
      final_report();
   end
endmodule
